//--- src/timer_pulse_unit_pkg.sv
// Constants, types and helpers for the six-channel timer pulse unit
package timer_pulse_unit_pkg;
    localparam int NCH  = 6;
    localparam int NGR  = 4;
    localparam int NPIN = NCH * NGR;
    localparam int CW   = 16;
    localparam int PW   = 12;
    // Register slots that exist (index = channel * 4 + register)
    localparam logic [NPIN-1:0] GR_VALID = 24'h33_f33f;
    localparam logic [NCH-1:0]  PHASE_CH = 6'h36;
    localparam logic [NCH-1:0]  CASC_CH  = 6'h12;
    localparam logic [NCH-1:0]  BUF_CH   = 6'h09;
    // Address fields: group in bits 8:6, word index in bits 5:2
    localparam logic [2:0] GRP_GLOBAL = 3'h0;
    localparam logic [3:0] IDX_STOP   = 4'h0;
    localparam logic [3:0] IDX_START  = 4'h1;
    localparam logic [3:0] IDX_SYNC   = 4'h2;
    localparam logic [3:0] IDX_CFG    = 4'h0;
    localparam logic [3:0] IDX_IOC    = 4'h1;
    localparam logic [3:0] IDX_STAT   = 4'h2;
    localparam logic [3:0] IDX_CNT    = 4'h3;
    localparam logic [3:0] IDX_GR     = 4'h4;
    // Channel configuration fields
    localparam int CFG_CLK  = 0;
    localparam int CFG_EXT  = 3;
    localparam int CFG_CLR  = 5;
    localparam int CFG_MODE = 8;
    localparam int CFG_PH   = 10;
    localparam int CFG_BUF  = 12;
    localparam int CFG_CASC = 14;
    // Per-register control nibble
    localparam int IO_CAP  = 0;
    localparam int IO_ACT  = 1;
    localparam int IO_INIT = 3;
    // Status bits
    localparam int FLG_OVF = 4;
    localparam int FLG_UNF = 5;
    localparam logic [2:0]    CLK_EXT  = 3'h7;
    localparam logic [2:0]    CLR_NONE = 3'h0;
    localparam logic [2:0]    CLR_LAST = 3'h4;
    localparam logic [1:0]    ACT_NONE = 2'h0;
    localparam logic [1:0]    ACT_LOW  = 2'h1;
    localparam logic [1:0]    ACT_HIGH = 2'h2;
    localparam logic [CW-1:0] CNT_MAX  = 16'hffff;
    localparam logic [CW-1:0] CNT_MIN  = 16'h0000;
    localparam logic [PW-1:0] PRE_ALL  = 12'hfff;
    localparam logic          STOP_RST = 1'b1;

    typedef enum logic [1:0] {MODE_NORMAL, MODE_PWM1, MODE_PWM2, MODE_PHASE} mode_t;

    // Tick of the clock divided by 4 to the power sel
    function automatic logic div_tick(input logic [PW-1:0] pre, input logic [2:0] sel);
        logic [PW-1:0] mask;
        mask = ~(PRE_ALL << {sel, 1'b0});
        return &(pre | ~mask);
    endfunction : div_tick

    function automatic logic act_apply(input logic cur, input logic [1:0] act);
        return (act == ACT_NONE) ? cur : (act == ACT_LOW) ? 1'b0 : (act == ACT_HIGH) ? 1'b1 : ~cur;
    endfunction : act_apply

    // Returns {up, down} for the two phase inputs and their previous levels
    function automatic logic [1:0] phase_step(input logic [1:0] v, input logic a,
                                              input logic b, input logic ap, input logic bp);
        logic ar;
        logic af;
        logic br;
        logic bf;
        ar = a & ~ap;
        af = ~a & ap;
        br = b & ~bp;
        bf = ~b & bp;
        case (v)
            2'h0:    return {(a & br) | (~a & bf) | (ar & ~b) | (af & b),
                             (a & bf) | (~a & br) | (ar & b) | (af & ~b)};
            2'h1:    return {af & b, af & ~b};
            2'h2:    return {af & b, a & bf};
            default: return {(a & br) | (~a & bf), (a & bf) | (~a & br)};
        endcase
    endfunction : phase_step
endpackage : timer_pulse_unit_pkg

//--- src/timer_pulse_unit.sv
// Six-channel 16-bit timer pulse unit with an AHB-Lite register slave
// Contract
// - Six independent channels, each with its own 16-bit counter.
// - Sixteen general registers; four on channels 0 and 3, two elsewhere.
// - Counter clock is one of seven prescaler taps or an external clock pin.
// - Compare match drives its pin low, high or toggles it.
// - Capture copies the counter on rising, falling or both pin edges.
// - Compare match or capture may clear the counter for cyclic counting.
// - Counter counts up: free running, cyclic or on external events.
// - Writing a synchronized counter writes all synchronized counters together.
// - Any clear on a synchronized channel clears all synchronized counters.
// - Buffered compare match reloads the target from its buffer register.
// - Buffered capture moves the old target value into the buffer.
// - First PWM mode pairs registers first/second and third/fourth.
// - Second PWM mode uses one period register, others as duty registers.
// - Channels 1, 2, 4, 5 count up/down from two-phase inputs, four variants.
// - Channel 1 or 4 counts overflow/underflow of channel 2 or 5.
// - Cascaded capture stores upper half in channel 1, lower in channel 2.
// - Twenty-six independent capture/compare, overflow and underflow requests.
// - Only capture/compare events request transfer controller service.
// - Channels 0 to 3 capture/compare events drive pulse pattern triggers.
// - Each channel's first register event is a converter start trigger.
// - Unit starts in module stop; registers inaccessible until released.
//
// Our own choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module timer_pulse_unit (
    // Clock and reset
    input  wire logic                                  hclk,
    input  wire logic                                  hresetn,
    // AHB-Lite slave
    input  wire logic                                  hsel,
    input  wire logic [31:0]                           haddr,
    input  wire logic [1:0]                            htrans,
    input  wire logic                                  hwrite,
    input  wire logic [2:0]                            hsize,
    input  wire logic [31:0]                           hwdata,
    input  wire logic                                  hready,
    output logic                                       hreadyout,
    output logic                                       hresp,
    output logic [31:0]                                hrdata,
    // External clock pins
    input  wire logic                                  ext_clock_in_a,
    input  wire logic                                  ext_clock_in_b,
    input  wire logic                                  ext_clock_in_c,
    input  wire logic                                  ext_clock_in_d,
    // Timer I/O pins, index channel * 4 + register
    input  wire logic [timer_pulse_unit_pkg::NPIN-1:0] timer_io_pin_in,
    output logic [timer_pulse_unit_pkg::NPIN-1:0]      timer_io_pin_out,
    output logic [timer_pulse_unit_pkg::NPIN-1:0]      timer_io_pin_oe,
    // Requests and triggers
    output logic [timer_pulse_unit_pkg::NPIN-1:0]      capcmp_irq,
    output logic [timer_pulse_unit_pkg::NCH-1:0]       overflow_irq,
    output logic [timer_pulse_unit_pkg::NCH-1:0]       underflow_irq,
    output logic [timer_pulse_unit_pkg::NPIN-1:0]      xfer_req,
    output logic [15:0]                                pulse_pattern_trig,
    output logic [timer_pulse_unit_pkg::NCH-1:0]       adc_start_trig
);
    import timer_pulse_unit_pkg::*;
    logic [NPIN-1:0] pin_s1_ff, pin_s2_ff, pin_s3_ff;
    logic [3:0]      ext_s1_ff, ext_s2_ff, ext_s3_ff;
    logic [PW-1:0]   pre_ff;
    logic            stop_ff, wr_pend_ff, hreadyout_ff, hresp_ff;
    logic [NCH-1:0]  start_ff, sync_ff, ovf_flag_ff, unf_flag_ff, nxt_ovf, nxt_unf, adc_ff;
    logic [CW-1:0]   cnt_ff [NCH], nxt_cnt [NCH];
    logic [CW-1:0]   gr_ff [NPIN], nxt_gr [NPIN];
    logic [15:0]     cfg_ff [NCH], ioc_ff [NCH];
    logic [NPIN-1:0] cc_flag_ff, nxt_cc, pin_out_ff, pin_oe_ff, nxt_pin, nxt_oe, xfer_ff;
    logic [15:0]     pattern_ff;
    logic [8:0]      wa_ff;
    logic [31:0]     hrdata_ff, rd_word;
    // Bus decode
    wire             in_range = (haddr[31:9] == 23'h00_0000);
    wire             addr_take = hsel & htrans[1] & hready & in_range;
    wire [2:0]       w_grp = wa_ff[8:6];
    wire [3:0]       w_idx = wa_ff[5:2];
    wire [2:0]       r_grp = haddr[8:6];
    wire [3:0]       r_idx = haddr[5:2];
    wire             w_glob = wr_pend_ff & (w_grp == GRP_GLOBAL);
    wire             wr_stop = w_glob & (w_idx == IDX_STOP);
    wire             wr_start = w_glob & ~stop_ff & (w_idx == IDX_START);
    wire             wr_sync = w_glob & ~stop_ff & (w_idx == IDX_SYNC);
    wire [3:0]       ext_raw = {ext_clock_in_d, ext_clock_in_c, ext_clock_in_b, ext_clock_in_a};
    wire [NCH-1:0]   wr_ch, wr_cnt, up_w, dn_w, ovf_w, unf_w, clr_src_w;
    wire [NPIN-1:0]  cap_w, mat_w, gwr_w;
    for (genvar c = 0; c < NCH; c++) begin : g_ch
        mode_t     md;
        wire       run = start_ff[c] & ~stop_ff;
        wire [2:0] ck = cfg_ff[c][CFG_CLK +: 3];
        wire [1:0] es = cfg_ff[c][CFG_EXT +: 2];
        wire [2:0] cs = cfg_ff[c][CFG_CLR +: 3];
        wire       erise = ext_s2_ff[es] & ~ext_s3_ff[es];
        wire       base = (ck == CLK_EXT) ? erise : div_tick(pre_ff, ck);
        wire [3:0] ev = cap_w[c*NGR +: NGR] | mat_w[c*NGR +: NGR];
        assign md = mode_t'(cfg_ff[c][CFG_MODE +: 2]);
        assign wr_ch[c] = wr_pend_ff & ~stop_ff & (w_grp == 3'(c + 1));
        assign wr_cnt[c] = wr_ch[c] & (w_idx == IDX_CNT);
        if (PHASE_CH[c]) begin : g_ph
            localparam int PA = (c == 2 || c == 4) ? 2 : 0;
            wire [1:0] ph = phase_step(cfg_ff[c][CFG_PH +: 2], ext_s2_ff[PA], ext_s2_ff[PA+1],
                                       ext_s3_ff[PA], ext_s3_ff[PA+1]);
            wire       phm = (md == MODE_PHASE);
            if (CASC_CH[c]) begin : g_cs
                wire casc = cfg_ff[c][CFG_CASC];
                // Upper half follows the lower channel's wrap
                assign up_w[c] = run & (phm ? ph[1] : casc ? ovf_w[c+1] : base);
                assign dn_w[c] = run & (phm ? ph[0] : casc & unf_w[c+1]);
            end else begin : g_nc
                assign up_w[c] = run & (phm ? ph[1] : base);
                assign dn_w[c] = run & phm & ph[0];
            end
        end else begin : g_up
            assign up_w[c] = run & base;
            assign dn_w[c] = 1'b0;
        end
        assign ovf_w[c] = up_w[c] & (cnt_ff[c] == CNT_MAX);
        assign unf_w[c] = dn_w[c] & (cnt_ff[c] == CNT_MIN);
        // Clear source picks register 1..4 of this channel
        assign clr_src_w[c] = (cs != CLR_NONE) & (cs <= CLR_LAST) & ev[2'(cs - 3'h1)];
        for (genvar k = 0; k < NGR; k++) begin : g_gr
            localparam int I = c * NGR + k;
            wire [3:0] io = ioc_ff[c][k*4 +: 4];
            wire       rise = pin_s2_ff[I] & ~pin_s3_ff[I];
            wire       fall = ~pin_s2_ff[I] & pin_s3_ff[I];
            if (GR_VALID[I]) begin : g_v
                assign cap_w[I] = ~stop_ff & io[IO_CAP]
                                  & ((io[IO_ACT] & rise) | (io[IO_ACT+1] & fall));
                assign mat_w[I] = ~io[IO_CAP] & (up_w[c] | dn_w[c]) & (cnt_ff[c] == gr_ff[I]);
                assign gwr_w[I] = wr_ch[c] & (w_idx == IDX_GR + 4'(k));
            end else begin : g_n
                assign cap_w[I] = 1'b0;
                assign mat_w[I] = 1'b0;
                assign gwr_w[I] = 1'b0;
            end
        end
    end

    wire [NPIN-1:0] ev_w = cap_w | mat_w;
    wire            sync_clr = |(clr_src_w & sync_ff);
    wire [NCH-1:0]  clr_w = clr_src_w | (sync_ff & {NCH{sync_clr}});
    wire            sync_wr = |(wr_cnt & sync_ff);
    wire [NCH-1:0]  cnt_ld = wr_cnt | (sync_ff & {NCH{sync_wr}});
    // Counters and general registers
    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            if (cnt_ld[c]) begin
                nxt_cnt[c] = hwdata[CW-1:0];
            end else if (clr_w[c]) begin
                nxt_cnt[c] = CNT_MIN;
            end else if (up_w[c]) begin
                nxt_cnt[c] = cnt_ff[c] + 16'h0001;
            end else if (dn_w[c]) begin
                nxt_cnt[c] = cnt_ff[c] - 16'h0001;
            end else begin
                nxt_cnt[c] = cnt_ff[c];
            end
        end
        for (int i = 0; i < NPIN; i++) begin
            if (gwr_w[i]) begin
                nxt_gr[i] = hwdata[CW-1:0];
            end else if (cap_w[i]) begin
                nxt_gr[i] = cnt_ff[i/NGR];
            end else begin
                nxt_gr[i] = gr_ff[i];
            end
        end
        for (int c = 0; c < NCH; c++) begin
            for (int k = 0; k < 2; k++) begin
                if (BUF_CH[c] && cfg_ff[c][CFG_BUF+k]) begin
                    if (mat_w[c*NGR+k] && !gwr_w[c*NGR+k]) begin
                        nxt_gr[c*NGR+k] = gr_ff[c*NGR+k+2];
                    end
                    if (cap_w[c*NGR+k] && !gwr_w[c*NGR+k+2]) begin
                        nxt_gr[c*NGR+k+2] = gr_ff[c*NGR+k];
                    end
                end
            end
        end
    end
    // Request flags; a new event wins over a software clear
    always_comb begin
        nxt_cc = cc_flag_ff;
        nxt_ovf = ovf_flag_ff;
        nxt_unf = unf_flag_ff;
        for (int c = 0; c < NCH; c++) begin
            if (wr_ch[c] && w_idx == IDX_STAT) begin
                nxt_cc[c*NGR +: NGR] = cc_flag_ff[c*NGR +: NGR] & ~hwdata[NGR-1:0];
                nxt_ovf[c] = ovf_flag_ff[c] & ~hwdata[FLG_OVF];
                nxt_unf[c] = unf_flag_ff[c] & ~hwdata[FLG_UNF];
            end
        end
        nxt_cc = nxt_cc | ev_w;
        nxt_ovf = nxt_ovf | ovf_w;
        nxt_unf = nxt_unf | unf_w;
    end
    // Pin waveform
    always_comb begin
        logic [3:0] io;
        logic [3:0] io2;
        mode_t      md;
        int         c;
        int         k;
        io = 4'h0;
        io2 = 4'h0;
        md = MODE_NORMAL;
        c = 0;
        k = 0;
        nxt_pin = pin_out_ff;
        nxt_oe = '0;
        for (int i = 0; i < NPIN; i++) begin
            c = i / NGR;
            k = i % NGR;
            io = ioc_ff[c][k*4 +: 4];
            io2 = ioc_ff[c][(k|1)*4 +: 4];
            md = mode_t'(cfg_ff[c][CFG_MODE +: 2]);
            if (!start_ff[c]) begin
                nxt_pin[i] = io[IO_INIT];
            end else if (md == MODE_PWM1) begin
                // Even pin set by its own match, reset by its partner
                if (k % 2 == 0 && mat_w[i]) begin
                    nxt_pin[i] = act_apply(pin_out_ff[i], io[IO_ACT +: 2]);
                end
                if (k % 2 == 0 && mat_w[c*NGR+(k|1)]) begin
                    nxt_pin[i] = act_apply(pin_out_ff[i], io2[IO_ACT +: 2]);
                end
            end else if (md == MODE_PWM2 && clr_w[c]) begin
                nxt_pin[i] = io[IO_INIT];
            end else if (mat_w[i]) begin
                nxt_pin[i] = act_apply(pin_out_ff[i], io[IO_ACT +: 2]);
            end
            if (GR_VALID[i] && !io[IO_CAP]) begin
                case (md)
                    MODE_PWM1: nxt_oe[i] = (k % 2 == 0);
                    MODE_PWM2: nxt_oe[i] = (3'(k + 1) != cfg_ff[c][CFG_CLR +: 3]);
                    default:   nxt_oe[i] = (io[IO_ACT +: 2] != ACT_NONE);
                endcase
            end
        end
    end
    // Register read mux; all but the stop register blocked while in module stop
    always_comb begin
        int rc;
        rc = 32'(r_grp) - 1;
        rd_word = 32'h0000_0000;
        if (r_grp == GRP_GLOBAL) begin
            case (r_idx)
                IDX_STOP:  rd_word[0] = stop_ff;
                IDX_START: rd_word[NCH-1:0] = stop_ff ? '0 : start_ff;
                IDX_SYNC:  rd_word[NCH-1:0] = stop_ff ? '0 : sync_ff;
                default:   rd_word = 32'h0000_0000;
            endcase
        end else if (!stop_ff && rc < NCH) begin
            case (r_idx)
                IDX_CFG:  rd_word[15:0] = cfg_ff[rc];
                IDX_IOC:  rd_word[15:0] = ioc_ff[rc];
                IDX_STAT: rd_word[5:0] = {unf_flag_ff[rc], ovf_flag_ff[rc],
                                          cc_flag_ff[rc*NGR +: NGR]};
                IDX_CNT:  rd_word[CW-1:0] = cnt_ff[rc];
                default: begin
                    if (r_idx >= IDX_GR && r_idx < IDX_GR + 4'(NGR)
                        && GR_VALID[rc*NGR + 32'(r_idx - IDX_GR)]) begin
                        rd_word[CW-1:0] = gr_ff[rc*NGR + 32'(r_idx - IDX_GR)];
                    end
                end
            endcase
        end
    end

    // Pin synchronisers and prescaler
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_s1_ff <= '0;
            pin_s2_ff <= '0;
            pin_s3_ff <= '0;
            ext_s1_ff <= 4'h0;
            ext_s2_ff <= 4'h0;
            ext_s3_ff <= 4'h0;
            pre_ff <= '0;
        end else begin
            pin_s1_ff <= timer_io_pin_in;
            pin_s2_ff <= pin_s1_ff;
            pin_s3_ff <= pin_s2_ff;
            ext_s1_ff <= ext_raw;
            ext_s2_ff <= ext_s1_ff;
            ext_s3_ff <= ext_s2_ff;
            pre_ff <= stop_ff ? '0 : pre_ff + 12'h001;
        end
    end

    // Zero-wait AHB-Lite slave, always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff <= 1'b0;
            wa_ff <= '0;
            hrdata_ff <= 32'h0000_0000;
            hreadyout_ff <= 1'b1;
            hresp_ff <= 1'b0;
        end else begin
            wr_pend_ff <= addr_take & hwrite;
            wa_ff <= haddr[8:0];
            hrdata_ff <= (addr_take & ~hwrite) ? rd_word : 32'h0000_0000;
            hreadyout_ff <= 1'b1;
            hresp_ff <= 1'b0;
        end
    end

    // Global control
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stop_ff <= STOP_RST;
            start_ff <= '0;
            sync_ff <= '0;
        end else begin
            if (wr_stop) stop_ff <= hwdata[0];
            if (wr_start) start_ff <= hwdata[NCH-1:0];
            if (wr_sync) sync_ff <= hwdata[NCH-1:0];
        end
    end

    // Channel state and outputs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_ff <= '{default: '0};
            gr_ff <= '{default: CNT_MAX};
            cfg_ff <= '{default: '0};
            ioc_ff <= '{default: '0};
            cc_flag_ff <= '0;
            ovf_flag_ff <= '0;
            unf_flag_ff <= '0;
            pin_out_ff <= '0;
            pin_oe_ff <= '0;
            xfer_ff <= '0;
            pattern_ff <= 16'h0000;
            adc_ff <= '0;
        end else begin
            cnt_ff <= nxt_cnt;
            gr_ff <= nxt_gr;
            for (int c = 0; c < NCH; c++) begin
                if (wr_ch[c] && w_idx == IDX_CFG) cfg_ff[c] <= hwdata[15:0];
                if (wr_ch[c] && w_idx == IDX_IOC) ioc_ff[c] <= hwdata[15:0];
                adc_ff[c] <= ev_w[c*NGR];
            end
            cc_flag_ff <= nxt_cc;
            ovf_flag_ff <= nxt_ovf;
            unf_flag_ff <= nxt_unf;
            pin_out_ff <= nxt_pin;
            pin_oe_ff <= nxt_oe;
            xfer_ff <= ev_w;
            pattern_ff <= ev_w[15:0];
        end
    end

    assign hreadyout = hreadyout_ff;
    assign hresp = hresp_ff;
    assign hrdata = hrdata_ff;
    assign timer_io_pin_out = pin_out_ff;
    assign timer_io_pin_oe = pin_oe_ff;
    assign capcmp_irq = cc_flag_ff;
    assign overflow_irq = ovf_flag_ff;
    assign underflow_irq = unf_flag_ff;
    assign xfer_req = xfer_ff;
    assign pulse_pattern_trig = pattern_ff;
    assign adc_start_trig = adc_ff;
endmodule : timer_pulse_unit

//--- sim/timer_pulse_unit_assertions.sv
// Port-level assertions for the timer pulse unit
`timescale 1ns/1ps
module timer_pulse_unit_assertions (
    // Clock and bus
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    // Pins, requests and triggers
    input wire logic [timer_pulse_unit_pkg::NPIN-1:0] timer_io_pin_oe,
    input wire logic [timer_pulse_unit_pkg::NPIN-1:0] capcmp_irq,
    input wire logic [timer_pulse_unit_pkg::NCH-1:0]  underflow_irq,
    input wire logic [timer_pulse_unit_pkg::NPIN-1:0] xfer_req,
    input wire logic [15:0]                           pulse_pattern_trig,
    input wire logic [timer_pulse_unit_pkg::NCH-1:0]  adc_start_trig
);
    import timer_pulse_unit_pkg::*;
    logic       taken, rd_ff, wr_stop_ff, stop_ff;
    logic [8:0] adr_ff;
    assign taken = hsel & htrans[1] & hready & (haddr[31:9] == 23'h0);
    // Shadow of the stop bit, updated at the end of its data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_ff      <= 1'b0;
            wr_stop_ff <= 1'b0;
            adr_ff     <= 9'h0;
            stop_ff    <= STOP_RST;
        end else begin
            rd_ff      <= taken & ~hwrite;
            wr_stop_ff <= taken & hwrite & (haddr[8:0] == 9'h0);
            adr_ff     <= haddr[8:0];
            stop_ff    <= wr_stop_ff ? hwdata[0] : stop_ff;
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    AST_READY: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    AST_XFER_FLAG: assert property ((xfer_req & ~capcmp_irq) == '0)
        else $error("transfer request without its flag");
    AST_ADC: assert property (adc_start_trig == {xfer_req[20], xfer_req[16],
        xfer_req[12], xfer_req[8], xfer_req[4], xfer_req[0]})
        else $error("converter trigger not tied to first register event");
    AST_PPG: assert property (pulse_pattern_trig == xfer_req[15:0])
        else $error("pattern trigger mismatch");
    AST_UNF: assert property (!underflow_irq[0] && !underflow_irq[3])
        else $error("underflow on a channel without one");
    AST_SLOTS: assert property (((timer_io_pin_oe | capcmp_irq) & ~GR_VALID) == '0)
        else $error("activity on a missing register slot");
    AST_STOP_QUIET: assert property (stop_ff && $past(stop_ff) |-> xfer_req == '0)
        else $error("event while halted");
    AST_STOP_READ: assert property (rd_ff && stop_ff && $past(stop_ff)
        && adr_ff != 9'h0 |-> hrdata == 32'h0)
        else $error("register readable while halted");
    cover property (adc_start_trig[1]);
    cover property (xfer_req[0] && capcmp_irq[0]);
    cover property (rd_ff && stop_ff);
endmodule : timer_pulse_unit_assertions

bind timer_pulse_unit timer_pulse_unit_assertions u_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .timer_io_pin_oe(timer_io_pin_oe),
    .capcmp_irq(capcmp_irq), .underflow_irq(underflow_irq), .xfer_req(xfer_req),
    .pulse_pattern_trig(pulse_pattern_trig), .adc_start_trig(adc_start_trig)
);

//--- sim/pin_source_model.sv
// Pulse sources on the timer pins and a quadrature encoder on the external clock pins
`timescale 1ns/1ps
module pin_source_model (
    // Clock
    input wire logic        hclk,
    // Requested levels and encoder enable
    input wire logic [23:0] level_req,
    input wire logic        enc_en,
    // Pins
    output logic [23:0]     pins,
    output logic [3:0]      ext_clk
);
    logic [1:0] ph_ff = 2'h0;
    assign pins = level_req;
    always_ff @(posedge hclk) begin
        if (enc_en) begin
            ph_ff <= ph_ff + 2'h1;
        end
    end
    // Gray order so only one phase moves per step
    assign ext_clk = {2{ph_ff[1], ph_ff[1] ^ ph_ff[0]}};
endmodule : pin_source_model

//--- sim/tb.sv
// Self-checking bench for the timer pulse unit
`timescale 1ns/1ps
module tb;
    import timer_pulse_unit_pkg::*;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [23:0] lvl = 24'h0;
    logic        enc_en = 1'b0;
    logic        rd_ph = 1'b0;
    logic [16:0] rnd = 17'h1_8359;
    logic [15:0] v1, v2;
    logic        prev;
    wire         hready;
    logic [31:0] hrdata;
    logic [23:0] pins;
    logic [3:0]  ext;
    logic [23:0] pin_out;
    logic [5:0]  adc, ovf;
    logic [31:0] q[$];
    int          failures = 0;
    int          total_checks = 0;
    int          cyc = 0;
    int          edges, pulses;

    timer_pulse_unit dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hresp(), .hrdata(hrdata), .ext_clock_in_a(ext[0]),
        .ext_clock_in_b(ext[1]), .ext_clock_in_c(ext[2]), .ext_clock_in_d(ext[3]),
        .timer_io_pin_in(pins), .timer_io_pin_out(pin_out), .timer_io_pin_oe(),
        .capcmp_irq(), .overflow_irq(ovf), .underflow_irq(), .xfer_req(),
        .pulse_pattern_trig(), .adc_start_trig(adc)
    );
    pin_source_model u_src (.hclk(hclk), .level_req(lvl), .enc_en(enc_en), .pins(pins),
        .ext_clk(ext));

    initial begin
        forever #12.5 hclk = ~hclk;
    end

    function automatic logic [16:0] lfsr(input logic [16:0] s);
        return {s[15:0], s[16] ^ s[13]};
    endfunction : lfsr

    function automatic logic [31:0] ra(input int ch, input int off);
        return 32'(64 * (ch + 1) + off);
    endfunction : ra

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic results();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : results

    task automatic wait_rdy();
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
    endtask : wait_rdy

    // Called just after an edge; read expectation queued for the monitor
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= a;
        if (!wr) q.push_back(d);
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        if (wr) hwdata <= d;
        wait_rdy();
    endtask : xfer

    always @(posedge hclk) begin
        if (rd_ph) check("read data", q.pop_front(), hrdata);
        rd_ph <= hsel & htrans[1] & ~hwrite & hready;
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            failures++;
            results();
        end
    end

    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        enc_en <= 1'b1;
        @(posedge hclk);
        xfer(0, 32'h0, 32'h1);
        xfer(1, ra(0, 0), 32'h1000);
        xfer(0, ra(0, 0), 32'h0);
        xfer(1, 32'h0, 32'h0);
        xfer(0, ra(3, 28), 32'hffff);
        xfer(0, 32'h200, 32'h0);
        xfer(1, ra(0, 0), 32'h1000);
        xfer(1, ra(0, 4), 32'h7);
        xfer(1, 32'h8, 32'h3);
        rnd = lfsr(rnd);
        v1 = rnd[15:0] | 16'h1;
        xfer(1, ra(0, 12), {16'h0, v1});
        xfer(0, ra(1, 12), {16'h0, v1});
        xfer(0, ra(2, 12), 32'h0);
        lvl[0] <= 1'b1;
        repeat (6) @(posedge hclk);
        rnd = lfsr(rnd);
        v2 = rnd[15:0] | 16'h1;
        xfer(1, ra(0, 12), {16'h0, v2});
        lvl[0] <= 1'b0;
        repeat (6) @(posedge hclk);
        xfer(0, ra(0, 16), {16'h0, v2});
        xfer(0, ra(0, 24), {16'h0, v1});
        xfer(0, ra(0, 8), 32'h1);
        // Period of four: match on 3, then clear
        xfer(1, ra(1, 16), 32'h3);
        xfer(1, ra(1, 4), 32'h6);
        xfer(1, ra(1, 0), 32'h20);
        xfer(1, ra(1, 12), 32'h2);
        xfer(1, 32'h4, 32'h2);
        repeat (10) @(posedge hclk);
        prev = pin_out[4];
        edges = 0;
        pulses = 0;
        repeat (40) begin
            @(posedge hclk);
            edges += int'(pin_out[4] !== prev);
            pulses += int'(adc[1] === 1'b1);
            prev = pin_out[4];
        end
        check("toggles", 32'd10, edges);
        check("adc pulses", 32'd10, pulses);
        // Encoder steps each clock, so channel 2 counts up each clock
        xfer(1, ra(2, 0), 32'h300);
        xfer(1, 32'h4, 32'h6);
        xfer(1, ra(2, 12), 32'hfffd);
        xfer(0, ra(0, 12), 32'h0);
        xfer(0, ra(2, 12), 32'hffff);
        check("overflow", 32'h4, ovf);
        results();
    end
endmodule : tb
